// File: hw/accel_register_bank.sv
// Byte-wide register bank of a three-axis shock accelerometer
//
// Summary of operation
// - Every register is eight bits; each address holds one byte.
// - Address zero is a read-only constant part code.
// - Shock threshold is unsigned; candidate magnitudes above it flag a shock.
// - One threshold step equals 780 milli-g in the comparison.
// - Reset loads rate control with 00001010 and irq source with 00000010.
// - Reset clears every other implemented register to zero, except the bus address register, which loads 0x53.
// - Serial bus address is 0x1D with select pin high, 0x53 when low.
`timescale 1ns/1ps
module accel_register_bank
	import accel_regs_pkg::*;
#(
	// Arbitrary neutral value, not a real part code
	parameter logic [7:0] PART_CODE = 8'h5a
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [accel_regs_pkg::ADDR_W-1:0] i_addr,
	input wire logic i_wr_en,
	input wire logic [accel_regs_pkg::DATA_W-1:0] i_wr_data,
	input wire logic i_rd_en,
	output logic [accel_regs_pkg::DATA_W-1:0] o_rd_data,
	output logic o_rd_valid,
	input wire logic i_status_valid,
	input wire logic [accel_regs_pkg::DATA_W-1:0] i_event_axis_source,
	input wire logic [accel_regs_pkg::DATA_W-1:0] i_irq_source_flags,
	input wire logic [accel_regs_pkg::SAMPLE_W-1:0] i_x_sample,
	input wire logic [accel_regs_pkg::SAMPLE_W-1:0] i_y_sample,
	input wire logic [accel_regs_pkg::SAMPLE_W-1:0] i_z_sample,
	input wire logic [accel_regs_pkg::DATA_W-1:0] i_sample_queue_status,
	input wire logic i_candidate_valid,
	input wire logic [accel_regs_pkg::MAG_W-1:0] i_magnitude_mg,
	output logic o_shock_detected,
	input wire logic i_bus_address_select_pin,
	output logic [6:0] o_bus_address,
	output logic [accel_regs_pkg::DATA_W-1:0] o_shock_threshold,
	output logic [accel_regs_pkg::DATA_W-1:0] o_x_offset_trim,
	output logic [accel_regs_pkg::DATA_W-1:0] o_y_offset_trim,
	output logic [accel_regs_pkg::DATA_W-1:0] o_z_offset_trim,
	output logic [accel_regs_pkg::DATA_W-1:0] o_shock_duration,
	output logic [accel_regs_pkg::DATA_W-1:0] o_shock_latency,
	output logic [accel_regs_pkg::DATA_W-1:0] o_second_shock_span,
	output logic [accel_regs_pkg::DATA_W-1:0] o_activity_threshold,
	output logic [accel_regs_pkg::DATA_W-1:0] o_inactivity_threshold,
	output logic [accel_regs_pkg::DATA_W-1:0] o_inactivity_time,
	output logic [accel_regs_pkg::DATA_W-1:0] o_motion_axis_control,
	output logic [accel_regs_pkg::DATA_W-1:0] o_shock_axis_control,
	output logic [accel_regs_pkg::DATA_W-1:0] o_rate_power_control,
	output logic [accel_regs_pkg::DATA_W-1:0] o_power_feature_control,
	output logic [accel_regs_pkg::DATA_W-1:0] o_irq_enable_mask,
	output logic [accel_regs_pkg::DATA_W-1:0] o_irq_pin_routing,
	output logic [accel_regs_pkg::DATA_W-1:0] o_output_format_control,
	output logic [accel_regs_pkg::DATA_W-1:0] o_sample_queue_control
);
	import accel_regs_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Host-writable registers

	logic [DATA_W-1:0] rw_q [NUM_ADDR];

	// one byte flop per writable address
	generate
		for (genvar g = 0; g < NUM_ADDR; g++) begin : g_reg
			if (is_rw(ADDR_W'(g))) begin : g_rw
				logic [DATA_W-1:0] next_val;
				always_comb begin
					next_val = rw_q[g];
					if (i_wr_en && i_addr == ADDR_W'(g)) begin
						next_val = i_wr_data;
					end
				end
				// rate control resets to its nonzero value; others clear
				always_ff @(posedge i_clk) begin
					if (i_rst) begin
						rw_q[g] <= reset_of(ADDR_W'(g));
					end else begin
						rw_q[g] <= next_val;
					end
				end
			end else begin : g_none
				// no write path, so writes here fall away
				always_ff @(posedge i_clk) begin
					rw_q[g] <= RST_ZERO;
				end
			end
		end
	endgenerate

	assign o_shock_threshold = rw_q[ADDR_SHOCK_THRESHOLD];
	assign o_x_offset_trim = rw_q[ADDR_X_OFFSET_TRIM];
	assign o_y_offset_trim = rw_q[ADDR_Y_OFFSET_TRIM];
	assign o_z_offset_trim = rw_q[ADDR_Z_OFFSET_TRIM];
	assign o_shock_duration = rw_q[ADDR_SHOCK_DURATION];
	assign o_shock_latency = rw_q[ADDR_SHOCK_LATENCY];
	assign o_second_shock_span = rw_q[ADDR_SECOND_SHOCK_SPAN];
	assign o_activity_threshold = rw_q[ADDR_ACTIVITY_THRESHOLD];
	assign o_inactivity_threshold = rw_q[ADDR_INACTIVITY_THRESHOLD];
	assign o_inactivity_time = rw_q[ADDR_INACTIVITY_TIME];
	assign o_motion_axis_control = rw_q[ADDR_MOTION_AXIS_CONTROL];
	assign o_shock_axis_control = rw_q[ADDR_SHOCK_AXIS_CONTROL];
	assign o_rate_power_control = rw_q[ADDR_RATE_POWER_CONTROL];
	assign o_power_feature_control = rw_q[ADDR_POWER_FEATURE_CONTROL];
	assign o_irq_enable_mask = rw_q[ADDR_IRQ_ENABLE_MASK];
	assign o_irq_pin_routing = rw_q[ADDR_IRQ_PIN_ROUTING];
	assign o_output_format_control = rw_q[ADDR_OUTPUT_FORMAT_CONTROL];
	assign o_sample_queue_control = rw_q[ADDR_SAMPLE_QUEUE_CONTROL];

	////////////////////////////////////////////////////////////////////////////////
	// Read-only state loaded by the sensing logic

	logic [DATA_W-1:0] event_src;
	logic [DATA_W-1:0] irq_src;
	logic [SAMPLE_W-1:0] x_sample;
	logic [SAMPLE_W-1:0] y_sample;
	logic [SAMPLE_W-1:0] z_sample;
	logic [DATA_W-1:0] queue_status;
	logic [DATA_W-1:0] next_event_src;
	logic [DATA_W-1:0] next_irq_src;
	logic [SAMPLE_W-1:0] next_x_sample;
	logic [SAMPLE_W-1:0] next_y_sample;
	logic [SAMPLE_W-1:0] next_z_sample;
	logic [DATA_W-1:0] next_queue_status;

	// only the sensing side updates these; host writes never reach them
	always_comb begin
		next_event_src = event_src;
		next_irq_src = irq_src;
		next_x_sample = x_sample;
		next_y_sample = y_sample;
		next_z_sample = z_sample;
		next_queue_status = queue_status;
		if (i_status_valid) begin
			next_event_src = i_event_axis_source;
			next_irq_src = i_irq_source_flags;
			next_x_sample = i_x_sample;
			next_y_sample = i_y_sample;
			next_z_sample = i_z_sample;
			next_queue_status = i_sample_queue_status;
		end
	end

	// irq source resets to 00000010; the rest clear
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			event_src <= RST_ZERO;
			irq_src <= RST_IRQ_SOURCE;
			x_sample <= {RST_ZERO, RST_ZERO};
			y_sample <= {RST_ZERO, RST_ZERO};
			z_sample <= {RST_ZERO, RST_ZERO};
			queue_status <= RST_ZERO;
		end else begin
			event_src <= next_event_src;
			irq_src <= next_irq_src;
			x_sample <= next_x_sample;
			y_sample <= next_y_sample;
			z_sample <= next_z_sample;
			queue_status <= next_queue_status;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read path

	logic [DATA_W-1:0] next_rd_data;
	logic [DATA_W-1:0] rd_mux;

	// address zero always returns the fixed code
	always_comb begin
		case (i_addr)
			ADDR_PART_IDENTITY: rd_mux = PART_CODE;
			ADDR_EVENT_AXIS_SOURCE: rd_mux = event_src;
			ADDR_IRQ_SOURCE_FLAGS: rd_mux = irq_src;
			ADDR_X_SAMPLE_LOW: rd_mux = x_sample[7:0];
			ADDR_X_SAMPLE_HIGH: rd_mux = x_sample[15:8];
			ADDR_Y_SAMPLE_LOW: rd_mux = y_sample[7:0];
			ADDR_Y_SAMPLE_HIGH: rd_mux = y_sample[15:8];
			ADDR_Z_SAMPLE_LOW: rd_mux = z_sample[7:0];
			ADDR_Z_SAMPLE_HIGH: rd_mux = z_sample[15:8];
			ADDR_SAMPLE_QUEUE_STATUS: rd_mux = queue_status;
			// Reserved and unmapped bytes read zero rather than stale data
			default: rd_mux = rw_q[i_addr];
		endcase
	end

	always_comb begin
		next_rd_data = o_rd_data;
		if (i_rd_en) begin
			next_rd_data = rd_mux;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_rd_data <= RST_ZERO;
			o_rd_valid <= 1'b0;
		end else begin
			o_rd_data <= next_rd_data;
			o_rd_valid <= i_rd_en;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Shock detection and bus address

	shock_compare u_shock_compare (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_threshold(o_shock_threshold),
		.i_magnitude_mg(i_magnitude_mg),
		.i_candidate_valid(i_candidate_valid),
		.o_shock(o_shock_detected)
	);

	logic [6:0] next_bus_address;

	// pin selects between the two serial bus addresses
	always_comb begin
		next_bus_address = i_bus_address_select_pin ? BUS_ADDR_PIN_HIGH : BUS_ADDR_PIN_LOW;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_bus_address <= BUS_ADDR_PIN_LOW;
		end else begin
			o_bus_address <= next_bus_address;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	logic [MAG_W-1:0] chk_limit;
	assign chk_limit = MAG_W'({10'h000, o_shock_threshold} * MG_PER_LSB);

	part_code_read_a: assert property (
		i_rd_en && i_addr == ADDR_PART_IDENTITY |=> o_rd_data == PART_CODE && o_rd_valid)
		else $error("part code read wrong");

	ro_write_ignored_a: assert property (
		i_wr_en && !is_rw(i_addr) && i_addr != ADDR_PART_IDENTITY
		##1 (i_rd_en && !i_wr_en && i_addr == $past(i_addr) && !i_status_valid
		&& !$past(i_status_valid))
		|=> o_rd_data == $past(rd_mux, 2))
		else $error("read-only register changed by write");

	rw_byte_back_a: assert property (
		(i_wr_en && is_rw(i_addr)) ##1 (i_rd_en && !i_wr_en && i_addr == $past(i_addr))
		|=> o_rd_data == $past(i_wr_data, 2))
		else $error("written byte not read back");

	reserved_zero_a: assert property (
		i_rd_en && i_addr >= ADDR_RSVD_FIRST && i_addr <= ADDR_RSVD_LAST |=> o_rd_data == RST_ZERO)
		else $error("reserved address read nonzero");

	reset_values_a: assert property (@(posedge i_clk) disable iff (1'b0)
		i_rst |=> o_rate_power_control == RST_RATE_POWER && irq_src == RST_IRQ_SOURCE)
		else $error("nonzero reset values wrong");

	reset_clear_a: assert property (@(posedge i_clk) disable iff (1'b0)
		i_rst |=> o_shock_threshold == RST_ZERO && o_sample_queue_control == RST_ZERO
		&& x_sample == 16'h0000 && o_rd_data == RST_ZERO && !o_shock_detected)
		else $error("register not cleared by reset");

	shock_above_a: assert property (
		i_candidate_valid && i_magnitude_mg > chk_limit |=> o_shock_detected)
		else $error("shock above threshold missed");

	shock_below_a: assert property (
		!(i_candidate_valid && i_magnitude_mg > chk_limit) |=> !o_shock_detected)
		else $error("shock flagged at or below scaled threshold");

	bus_address_a: assert property (
		i_bus_address_select_pin ##1 i_bus_address_select_pin
		|-> o_bus_address == BUS_ADDR_PIN_HIGH)
		else $error("bus address wrong for select pin");

	write_lands_a: assert property (
		i_wr_en && i_addr == ADDR_SHOCK_THRESHOLD |=> o_shock_threshold == $past(i_wr_data))
		else $error("threshold write did not land");

	rd_data_hold_a: assert property (
		!i_rd_en |=> $stable(o_rd_data) && !o_rd_valid)
		else $error("read data moved without a read");

	rd_valid_pulse_a: assert property (
		i_rd_en |=> o_rd_valid)
		else $error("read valid missing after read strobe");

	status_load_a: assert property (
		i_status_valid
		|=> x_sample == $past(i_x_sample) && irq_src == $past(i_irq_source_flags))
		else $error("status inputs not latched");

	bus_address_low_a: assert property (
		!i_bus_address_select_pin ##1 !i_bus_address_select_pin
		|-> o_bus_address == BUS_ADDR_PIN_LOW)
		else $error("bus address wrong for low select pin");

	cover_id_read: cover property (i_rd_en && i_addr == ADDR_PART_IDENTITY ##1 o_rd_valid);
	cover_thresh_rw: cover property (
		i_wr_en && i_addr == ADDR_SHOCK_THRESHOLD ##1 i_rd_en && i_addr == ADDR_SHOCK_THRESHOLD);
	cover_shock: cover property (o_shock_detected && o_shock_threshold != RST_ZERO);
	cover_addr_low: cover property (!i_bus_address_select_pin ##1 o_bus_address == BUS_ADDR_PIN_LOW);
endmodule

// File: hw/accel_regs_pkg.sv
// Shared constants for the accelerometer register bank
package accel_regs_pkg;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 8;
	localparam int SAMPLE_W = 16;
	localparam int MAG_W = 18;
	localparam int NUM_ADDR = 64;

	localparam logic [ADDR_W-1:0] ADDR_PART_IDENTITY = 6'h00;
	localparam logic [ADDR_W-1:0] ADDR_RSVD_FIRST = 6'h01;
	localparam logic [ADDR_W-1:0] ADDR_RSVD_LAST = 6'h1c;
	localparam logic [ADDR_W-1:0] ADDR_SHOCK_THRESHOLD = 6'h1d;
	localparam logic [ADDR_W-1:0] ADDR_X_OFFSET_TRIM = 6'h1e;
	localparam logic [ADDR_W-1:0] ADDR_Y_OFFSET_TRIM = 6'h1f;
	localparam logic [ADDR_W-1:0] ADDR_Z_OFFSET_TRIM = 6'h20;
	localparam logic [ADDR_W-1:0] ADDR_SHOCK_DURATION = 6'h21;
	localparam logic [ADDR_W-1:0] ADDR_SHOCK_LATENCY = 6'h22;
	localparam logic [ADDR_W-1:0] ADDR_SECOND_SHOCK_SPAN = 6'h23;
	localparam logic [ADDR_W-1:0] ADDR_ACTIVITY_THRESHOLD = 6'h24;
	localparam logic [ADDR_W-1:0] ADDR_INACTIVITY_THRESHOLD = 6'h25;
	localparam logic [ADDR_W-1:0] ADDR_INACTIVITY_TIME = 6'h26;
	localparam logic [ADDR_W-1:0] ADDR_MOTION_AXIS_CONTROL = 6'h27;
	localparam logic [ADDR_W-1:0] ADDR_SHOCK_AXIS_CONTROL = 6'h2a;
	localparam logic [ADDR_W-1:0] ADDR_EVENT_AXIS_SOURCE = 6'h2b;
	localparam logic [ADDR_W-1:0] ADDR_RATE_POWER_CONTROL = 6'h2c;
	localparam logic [ADDR_W-1:0] ADDR_POWER_FEATURE_CONTROL = 6'h2d;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE_MASK = 6'h2e;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_PIN_ROUTING = 6'h2f;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_SOURCE_FLAGS = 6'h30;
	localparam logic [ADDR_W-1:0] ADDR_OUTPUT_FORMAT_CONTROL = 6'h31;
	localparam logic [ADDR_W-1:0] ADDR_X_SAMPLE_LOW = 6'h32;
	localparam logic [ADDR_W-1:0] ADDR_X_SAMPLE_HIGH = 6'h33;
	localparam logic [ADDR_W-1:0] ADDR_Y_SAMPLE_LOW = 6'h34;
	localparam logic [ADDR_W-1:0] ADDR_Y_SAMPLE_HIGH = 6'h35;
	localparam logic [ADDR_W-1:0] ADDR_Z_SAMPLE_LOW = 6'h36;
	localparam logic [ADDR_W-1:0] ADDR_Z_SAMPLE_HIGH = 6'h37;
	localparam logic [ADDR_W-1:0] ADDR_SAMPLE_QUEUE_CONTROL = 6'h38;
	localparam logic [ADDR_W-1:0] ADDR_SAMPLE_QUEUE_STATUS = 6'h39;

	localparam logic [DATA_W-1:0] RST_ZERO = 8'h00;
	localparam logic [DATA_W-1:0] RST_RATE_POWER = 8'h0a;
	localparam logic [DATA_W-1:0] RST_IRQ_SOURCE = 8'h02;

	// Threshold scale in milli-g per step
	localparam logic [MAG_W-1:0] MG_PER_LSB = 18'h0030c;

	localparam logic [6:0] BUS_ADDR_PIN_HIGH = 7'h1d;
	localparam logic [6:0] BUS_ADDR_PIN_LOW = 7'h53;

	// Host-writable addresses
	function automatic logic is_rw(input logic [ADDR_W-1:0] a);
		return (a >= ADDR_SHOCK_THRESHOLD && a <= ADDR_MOTION_AXIS_CONTROL) ||
			a == ADDR_SHOCK_AXIS_CONTROL ||
			(a >= ADDR_RATE_POWER_CONTROL && a <= ADDR_IRQ_PIN_ROUTING) ||
			a == ADDR_OUTPUT_FORMAT_CONTROL || a == ADDR_SAMPLE_QUEUE_CONTROL;
	endfunction

	function automatic logic [DATA_W-1:0] reset_of(input logic [ADDR_W-1:0] a);
		return (a == ADDR_RATE_POWER_CONTROL) ? RST_RATE_POWER : RST_ZERO;
	endfunction
endpackage

// File: hw/shock_compare.sv
// Shock threshold comparator with scaled threshold
`timescale 1ns/1ps
module shock_compare
	import accel_regs_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [accel_regs_pkg::DATA_W-1:0] i_threshold,
	input wire logic [accel_regs_pkg::MAG_W-1:0] i_magnitude_mg,
	input wire logic i_candidate_valid,
	output logic o_shock
);
	logic [MAG_W-1:0] limit_mg;
	logic next_shock;

	// scale by 780 mg per step
	always_comb begin
		limit_mg = MAG_W'({10'h000, i_threshold} * MG_PER_LSB);
	end

	always_comb begin
		next_shock = i_candidate_valid && (i_magnitude_mg > limit_mg);
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_shock <= 1'b0;
		end else begin
			o_shock <= next_shock;
		end
	end
endmodule

// File: verification/host_model.sv
// Host side of the byte register port: single byte writes and reads
`timescale 1ns/1ps
module host_model
	import accel_regs_pkg::*;
(
	input wire logic i_clk,
	output logic [accel_regs_pkg::ADDR_W-1:0] o_addr,
	output logic o_wr_en,
	output logic [accel_regs_pkg::DATA_W-1:0] o_wr_data,
	output logic o_rd_en,
	input wire logic [accel_regs_pkg::DATA_W-1:0] i_rd_data,
	input wire logic i_rd_valid
);
	initial begin
		o_addr = 6'h00;
		o_wr_en = 1'b0;
		o_wr_data = 8'h00;
		o_rd_en = 1'b0;
	end
	////////////////////////////////////////////////////////////////
	// Callers enter at a falling edge; strobes stay up so back to back
	// requests never assign a strobe twice in one step
	// callers skip reserved span
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		o_addr = a;
		o_wr_data = d;
		o_wr_en = 1'b1;
		o_rd_en = 1'b0;
		@(negedge i_clk);
	endtask
	task automatic rd(input logic [5:0] a, output logic [7:0] d);
		o_addr = a;
		o_rd_en = 1'b1;
		o_wr_en = 1'b0;
		@(negedge i_clk);
		d = i_rd_valid ? i_rd_data : 8'hxx;
	endtask
	task automatic idle();
		o_wr_en = 1'b0;
		o_rd_en = 1'b0;
		@(negedge i_clk);
	endtask
endmodule

// File: verification/tb_accel_register_bank.sv
// Self-checking bench for the accelerometer register bank
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
	$display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module tb_accel_register_bank;
	import accel_regs_pkg::*;
	// Arbitrary part code for this run
	localparam logic [7:0] CODE = 8'h3c;
	int error_cnt;
	int num_checks;
	logic i_clk, i_rst, i_wr_en, i_rd_en, o_rd_valid, i_status_valid;
	logic [ADDR_W-1:0] i_addr;
	logic [DATA_W-1:0] i_wr_data, o_rd_data, i_event_axis_source, i_irq_source_flags;
	logic [DATA_W-1:0] i_sample_queue_status, o_shock_threshold, o_rate_power_control;
	logic [SAMPLE_W-1:0] i_x_sample, i_y_sample, i_z_sample;
	logic i_candidate_valid, o_shock_detected, i_bus_address_select_pin;
	logic [MAG_W-1:0] i_magnitude_mg;
	logic [6:0] o_bus_address;
	logic [7:0] mdl [64];
	wire [15:0][7:0] outs;
	// Addresses of the register outputs held in outs, in port order
	localparam logic [5:0] OUT_ADDR [16] = '{6'h1e, 6'h1f, 6'h20, 6'h21, 6'h22, 6'h23,
		6'h24, 6'h25, 6'h26, 6'h27, 6'h2a, 6'h2d, 6'h2e, 6'h2f, 6'h31, 6'h38};

	accel_register_bank #(.PART_CODE(CODE)) DUT (.i_clk, .i_rst, .i_addr, .i_wr_en,
		.i_wr_data, .i_rd_en, .o_rd_data, .o_rd_valid, .i_status_valid,
		.i_event_axis_source, .i_irq_source_flags, .i_x_sample, .i_y_sample, .i_z_sample,
		.i_sample_queue_status, .i_candidate_valid, .i_magnitude_mg, .o_shock_detected,
		.i_bus_address_select_pin, .o_bus_address, .o_shock_threshold,
		.o_x_offset_trim(outs[0]), .o_y_offset_trim(outs[1]), .o_z_offset_trim(outs[2]),
		.o_shock_duration(outs[3]), .o_shock_latency(outs[4]), .o_second_shock_span(outs[5]),
		.o_activity_threshold(outs[6]), .o_inactivity_threshold(outs[7]),
		.o_inactivity_time(outs[8]), .o_motion_axis_control(outs[9]),
		.o_shock_axis_control(outs[10]), .o_rate_power_control,
		.o_power_feature_control(outs[11]), .o_irq_enable_mask(outs[12]),
		.o_irq_pin_routing(outs[13]), .o_output_format_control(outs[14]),
		.o_sample_queue_control(outs[15]));
	host_model host (.i_clk, .o_addr(i_addr), .o_wr_en(i_wr_en), .o_wr_data(i_wr_data),
		.o_rd_en(i_rd_en), .i_rd_data(o_rd_data), .i_rd_valid(o_rd_valid));

	////////////////////////////////////////////////////////////////
	function automatic logic rw_addr(input logic [5:0] a);
		return (a >= 6'h1d && a <= 6'h27) || a == 6'h2a || (a >= 6'h2c && a <= 6'h2f) ||
			a == 6'h31 || a == 6'h38;
	endfunction
	task automatic init_model();
		foreach (mdl[i]) mdl[i] = 8'h00;
		mdl[6'h00] = CODE;
		mdl[6'h2c] = 8'h0a;
		mdl[6'h30] = 8'h02;
	endtask
	// Unmapped places stay zero in the model, matching the refused-read value
	task automatic check_all();
		logic [7:0] d;
		for (int k = 0; k < 16; k++) begin
			`CHK("reg out", mdl[OUT_ADDR[k]], outs[k]);
		end
		for (int a = 0; a < 64; a++) begin
			if (a == 0 || a > 28) begin
				host.rd(6'(a), d);
				`CHK("reg read", mdl[a], d);
			end
		end
		host.idle();
	endtask
	task automatic load_status();
		i_event_axis_source = 8'($urandom);
		i_irq_source_flags = 8'($urandom);
		i_x_sample = 16'($urandom);
		i_y_sample = 16'($urandom);
		i_z_sample = 16'($urandom);
		i_sample_queue_status = 8'($urandom);
		i_status_valid = 1'b1;
		@(negedge i_clk);
		i_status_valid = 1'b0;
		mdl[6'h2b] = i_event_axis_source;
		mdl[6'h30] = i_irq_source_flags;
		{mdl[6'h33], mdl[6'h32]} = i_x_sample;
		{mdl[6'h35], mdl[6'h34]} = i_y_sample;
		{mdl[6'h37], mdl[6'h36]} = i_z_sample;
		mdl[6'h39] = i_sample_queue_status;
	endtask
	// Boundary magnitudes around the scaled threshold, back to back
	task automatic shock_run(input logic [7:0] t);
		int lim;
		logic e;
		host.wr(6'h1d, t);
		host.idle();
		lim = int'(t) * 780;
		for (int k = 0; k < 6; k++) begin
			i_candidate_valid = (k != 5);
			case (k)
				0: i_magnitude_mg = 18'(lim);
				1, 5: i_magnitude_mg = 18'(lim + 1);
				2: i_magnitude_mg = 18'(lim - 1);
				default: i_magnitude_mg = 18'($urandom_range(0, 250000));
			endcase
			e = i_candidate_valid && (int'(i_magnitude_mg) > lim);
			@(negedge i_clk);
			`CHK("shock", e, o_shock_detected);
		end
		i_candidate_valid = 1'b0;
	endtask
	task automatic test_done();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end
	initial begin
		#2000000;
		error_cnt++;
		test_done();
	end
	initial begin
		logic [7:0] d;
		error_cnt = 0;
		num_checks = 0;
		i_rst = 1'b1;
		i_status_valid = 1'b0;
		i_candidate_valid = 1'b0;
		i_magnitude_mg = 18'h00000;
		i_bus_address_select_pin = 1'b0;
		void'($urandom(32'h81d75e07));
		repeat (4) @(posedge i_clk);
		@(negedge i_clk);
		i_rst = 1'b0;
		@(negedge i_clk);
		init_model();
		`CHK("rate out", 8'h0a, o_rate_power_control);
		check_all();
		for (int r = 0; r < 3; r++) begin
			load_status();
			for (int a = 0; a < 64; a++) begin
				if (a == 0 || a > 28) begin
					d = 8'($urandom);
					if (a == 29) d[0] = 1'b1;
					host.wr(6'(a), d);
					if (rw_addr(6'(a))) mdl[a] = d;
					host.rd(6'(a), d);
					`CHK("wr then rd", mdl[a], d);
				end
			end
			host.idle();
			`CHK("thr out", mdl[29], o_shock_threshold);
			check_all();
		end
		// Mid-run reset must restore every default
		i_rst = 1'b1;
		@(negedge i_clk);
		i_rst = 1'b0;
		@(negedge i_clk);
		init_model();
		check_all();
		shock_run(8'h01);
		shock_run(8'hff);
		repeat (3) shock_run(8'($urandom_range(1, 255)));
		for (int p = 0; p < 4; p++) begin
			i_bus_address_select_pin = p[0];
			@(negedge i_clk);
			`CHK("bus addr", p[0] ? 7'h1d : 7'h53, o_bus_address);
		end
		test_done();
	end
endmodule
